// >>> shared/tlc_pkg.sv
// Package for the traffic-channel test loop controller: constants, types, notes
// Functional notes
// - Test functions change only on layer 3 commands over the control channel, acknowledged.
// - Test SIM removal or power-off deactivates every active test function.
// - Traffic loops and the digital audio test port never run together.
// - Ignore a loop close request if no traffic channel or a loop already closed.
// - Otherwise close the requested loop and send a loop close confirmation.
// - Loop A feeds good decoded frames back to the encoder, uplink, same channel.
// - Full and half rate speech loops 260 bits in loops A and B.
// - Enhanced full rate speech loops 244 bits in loops A and B.
// - Loop A sends an all-zero frame uplink for a bad speech frame.
// - Loop A uplink content for fast control frames is undefined; control works normally.
// - Loop B loops every speech frame without signalling erasures.
// - Loop C sends the 114 decrypted, undecoded information bits of each burst uplink.
// - Loop C retransmits regardless of midamble, uplink uses own normal midamble.
// - Loop C never loops slow control or idle bursts.
// - Loop C operates within 104 frames after the confirmation.
// - Loop C round-trip delay is fixed, declared and below 26 frames.
// - Uplink slow control frame keeps its position; later bursts slip one frame.
// - Loop C is supported whenever any traffic channel is supported.
// - Loop D loops reliable frames; bad, unreliable or fast control frames go zero.
// - Loop E loops valid and invalid silence frames; erased silence frames go zero.
package tlc_pkg;
	localparam int FRAME_W = 260;
	localparam int BURST_W = 114;
	localparam int FIFO_DEPTH = 8;
	localparam logic [8:0] SPEECH_BITS = 9'h104;
	localparam logic [8:0] EFR_BITS = 9'h0F4;
	localparam logic [7:0] CONFIRM_WINDOW_FRAMES = 8'h68;
	localparam logic [4:0] RTD_LIMIT_FRAMES = 5'h1A;
	localparam logic [4:0] RTD_FRAMES = 5'h05;
	localparam logic [1:0] SID_ERASED = 2'h0;
	localparam logic [1:0] SID_INVALID = 2'h1;
	localparam logic [1:0] SID_VALID = 2'h2;

	typedef enum logic [2:0] {TLC_LOOP_A, TLC_LOOP_B, TLC_LOOP_C, TLC_LOOP_D, TLC_LOOP_E, TLC_LOOP_F} tlc_loop_t;
	typedef enum logic [1:0] {TLC_CH_FULL, TLC_CH_HALF, TLC_CH_EFR, TLC_CH_DATA} tlc_chan_t;

	typedef struct packed {
		logic [FRAME_W-1:0] bits;
		logic               bad_frame_flag;
		logic               unreliable_frame_flag;
		logic               fast_ctrl;
		logic [1:0]         silence_descriptor_class;
	} tlc_frame_t;

	typedef struct packed {
		logic [BURST_W-1:0] bits;
		logic               slow_ctrl;
		logic               idle;
	} tlc_burst_t;
endpackage

// >>> core/tlc_fifo.sv
// Valid/ready FIFO in flip-flops
`timescale 1ns/10ps
module tlc_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input  wire logic         clk_in,
	input  wire logic         rstn_in,
	input  wire logic         flush_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	input  wire logic [W-1:0] in_data_in,
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic [W-1:0]      out_data_out
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_reg [D];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0]   cnt_reg;
	wire           push = in_valid_in && in_ready_out;
	wire           pop  = out_valid_out && out_ready_in;

	assign in_ready_out  = (cnt_reg != D[AW:0]);
	assign out_valid_out = (cnt_reg != '0);
	assign out_data_out  = mem_reg[rd_reg];

	always_ff @(posedge clk_in) begin
		if (push)
			mem_reg[wr_reg] <= in_data_in;
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else if (flush_in) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg  <= push ? AW'(wr_reg + 1'b1) : wr_reg;
			rd_reg  <= pop ? AW'(rd_reg + 1'b1) : rd_reg;
			cnt_reg <= (AW+1)'(cnt_reg + push - pop);
		end
	end
endmodule

// >>> core/tlc_loop_ctrl.sv
// Traffic-channel test loop controller: command handling and frame/burst loopback
`timescale 1ns/10ps
module tlc_loop_ctrl (
	input  wire logic                clk_sys_in,
	input  wire logic                rstn_in,
	input  wire logic                frame_tick_in,
	input  wire logic                l3_close_req_in,
	input  wire tlc_pkg::tlc_loop_t  l3_close_loop_in,
	input  wire logic                l3_open_req_in,
	input  wire logic                tch_active_in,
	input  wire tlc_pkg::tlc_chan_t  tch_type_in,
	input  wire logic                test_sim_present_in,
	input  wire logic                power_down_in,
	input  wire logic                dai_active_in,
	input  wire logic                dec_valid_in,
	input  wire tlc_pkg::tlc_frame_t dec_frame_in,
	input  wire logic                burst_valid_in,
	input  wire tlc_pkg::tlc_burst_t burst_in,
	input  wire logic                enc_ready_in,
	output logic                     enc_valid_out,
	output logic [tlc_pkg::FRAME_W-1:0] enc_bits_out,
	output logic [8:0]               enc_len_out,
	output logic                     ul_burst_valid_out,
	output logic [tlc_pkg::BURST_W-1:0] ul_burst_out,
	output logic                     l3_confirm_out,
	output logic                     loop_closed_out,
	output logic                     burst_loop_live_out,
	output logic                     dai_allowed_out,
	output logic                     fifo_full_out
);
	typedef enum logic [1:0] {TLC_OPEN, TLC_CLOSED} tlc_state_t;

	//////////////////////////////////////////////////////////////////////////////
	// Reset release and pin sync
	logic [1:0] rst_sync_reg;
	wire        rstn = rst_sync_reg[1];
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end

	logic [1:0] sim_sync_reg;
	logic [1:0] pwr_sync_reg;
	always_ff @(posedge clk_sys_in or negedge rstn) begin
		if (!rstn) begin
			sim_sync_reg <= 2'b00;
			pwr_sync_reg <= 2'b11;
		end else begin
			sim_sync_reg <= {sim_sync_reg[0], test_sim_present_in};
			pwr_sync_reg <= {pwr_sync_reg[0], power_down_in};
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Command handling
	tlc_state_t         state_reg;
	tlc_pkg::tlc_loop_t mode_reg;
	tlc_pkg::tlc_chan_t chan_reg;
	logic [4:0]         rtd_reg;

	wire deact      = !sim_sync_reg[1] || pwr_sync_reg[1] || l3_open_req_in;
	wire closed     = (state_reg == TLC_CLOSED);
	wire accept     = l3_close_req_in && tch_active_in && !closed && !dai_active_in && !deact;
	wire is_burst   = closed && (mode_reg == tlc_pkg::TLC_LOOP_C);
	wire burst_live = is_burst && (rtd_reg == tlc_pkg::RTD_FRAMES);

	always_ff @(posedge clk_sys_in or negedge rstn) begin
		if (!rstn) begin
			state_reg <= TLC_OPEN;
			mode_reg  <= tlc_pkg::TLC_LOOP_A;
			chan_reg  <= tlc_pkg::TLC_CH_FULL;
		end else if (deact || !tch_active_in) begin
			state_reg <= TLC_OPEN;
		end else if (accept) begin
			state_reg <= TLC_CLOSED;
			mode_reg  <= l3_close_loop_in;
			chan_reg  <= tch_type_in;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn) begin
		if (!rstn)
			l3_confirm_out <= 1'b0;
		else
			l3_confirm_out <= accept;
	end

	// Fixed delay counted in TDMA frames; live well inside the reporting window
	always_ff @(posedge clk_sys_in or negedge rstn) begin
		if (!rstn)
			rtd_reg <= '0;
		else if (!is_burst)
			rtd_reg <= '0;
		else if (frame_tick_in && (rtd_reg != tlc_pkg::RTD_FRAMES))
			rtd_reg <= rtd_reg + 5'h01;
	end

	//////////////////////////////////////////////////////////////////////////////
	// Frame loops A, B, D, E, F
	wire sid_ok   = (dec_frame_in.silence_descriptor_class == tlc_pkg::SID_VALID)
	             || (dec_frame_in.silence_descriptor_class == tlc_pkg::SID_INVALID);
	wire zero_a   = dec_frame_in.bad_frame_flag || dec_frame_in.fast_ctrl;
	wire zero_d   = dec_frame_in.bad_frame_flag || dec_frame_in.unreliable_frame_flag
	             || dec_frame_in.fast_ctrl;
	wire zero_e   = !sid_ok || dec_frame_in.fast_ctrl;
	wire zero_f   = (dec_frame_in.silence_descriptor_class != tlc_pkg::SID_VALID) || zero_d;
	logic zero_sel;
	always_comb begin
		unique case (mode_reg)
			tlc_pkg::TLC_LOOP_A: zero_sel = zero_a;
			tlc_pkg::TLC_LOOP_B: zero_sel = 1'b0;
			tlc_pkg::TLC_LOOP_D: zero_sel = zero_d;
			tlc_pkg::TLC_LOOP_E: zero_sel = zero_e;
			tlc_pkg::TLC_LOOP_F: zero_sel = zero_f;
			default:             zero_sel = 1'b0;
		endcase
	end
	wire [8:0] frame_len = (chan_reg == tlc_pkg::TLC_CH_EFR) ? tlc_pkg::EFR_BITS : tlc_pkg::SPEECH_BITS;
	wire [tlc_pkg::FRAME_W-1:0] len_mask = {tlc_pkg::FRAME_W{1'b1}} >> (9'(tlc_pkg::FRAME_W) - frame_len);
	wire frame_loop = closed && !is_burst;
	wire [tlc_pkg::FRAME_W-1:0] frame_bits = zero_sel ? '0 : (dec_frame_in.bits & len_mask);

	//////////////////////////////////////////////////////////////////////////////
	// Burst loop C through the FIFO
	wire                        bq_in_valid = is_burst && burst_valid_in
	                                       && !burst_in.slow_ctrl && !burst_in.idle;
	wire                        bq_out_valid;
	wire [tlc_pkg::BURST_W-1:0] bq_out_data;
	wire                        bq_in_ready;
	wire                        bq_pop = burst_live && frame_tick_in && bq_out_valid;

	tlc_fifo #(
		.W (tlc_pkg::BURST_W),
		.D (tlc_pkg::FIFO_DEPTH)
	) u_burst_fifo (
		.clk_in        (clk_sys_in),
		.rstn_in       (rstn),
		.flush_in      (!is_burst),
		.in_valid_in   (bq_in_valid),
		.in_ready_out  (bq_in_ready),
		.in_data_in    (burst_in.bits),
		.out_valid_out (bq_out_valid),
		.out_ready_in  (bq_pop),
		.out_data_out  (bq_out_data)
	);

	//////////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge clk_sys_in or negedge rstn) begin
		if (!rstn) begin
			enc_valid_out       <= 1'b0;
			enc_bits_out        <= '0;
			enc_len_out         <= '0;
			ul_burst_valid_out  <= 1'b0;
			ul_burst_out        <= '0;
			loop_closed_out     <= 1'b0;
			burst_loop_live_out <= 1'b0;
			dai_allowed_out     <= 1'b1;
			fifo_full_out       <= 1'b0;
		end else begin
			enc_valid_out       <= frame_loop && dec_valid_in && enc_ready_in;
			if (frame_loop && dec_valid_in) begin
				enc_bits_out <= frame_bits;
				enc_len_out  <= frame_len;
			end
			ul_burst_valid_out  <= bq_pop;
			if (bq_pop)
				ul_burst_out <= bq_out_data;
			loop_closed_out     <= closed;
			burst_loop_live_out <= burst_live;
			dai_allowed_out     <= !closed && !accept;
			fifo_full_out       <= !bq_in_ready;
		end
	end
endmodule

// >>> verif/tlc_loop_ctrl_properties.sv
// Port checks for the test loop controller
`timescale 1ns/10ps
module tlc_loop_ctrl_properties (
	input wire logic                clk_sys_in,
	input wire logic                rstn_in,
	input wire logic                frame_tick_in,
	input wire logic                l3_close_req_in,
	input wire logic                tch_active_in,
	input wire tlc_pkg::tlc_chan_t  tch_type_in,
	input wire logic                test_sim_present_in,
	input wire logic                power_down_in,
	input wire logic                dai_active_in,
	input wire logic                enc_valid_out,
	input wire logic [259:0]        enc_bits_out,
	input wire logic [8:0]          enc_len_out,
	input wire logic                ul_burst_valid_out,
	input wire logic                l3_confirm_out,
	input wire logic                loop_closed_out,
	input wire logic                burst_loop_live_out,
	input wire logic                dai_allowed_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	// Channel type is latched when the request is taken, one cycle before the confirm
	tlc_pkg::tlc_chan_t type_d;
	tlc_pkg::tlc_chan_t chan_at_close;
	always_ff @(posedge clk_sys_in) begin
		type_d <= tch_type_in;
		if (l3_confirm_out)
			chan_at_close <= type_d;
	end
	sequence s_confirm;
		l3_confirm_out;
	endsequence
	a_confirm_cause: assert property (l3_confirm_out |-> $past(l3_close_req_in) && $past(tch_active_in)
		&& !$past(dai_active_in) && !$past(loop_closed_out)) else $error("confirm without accepted request");
	a_confirm_then_closed: assert property (s_confirm |=> loop_closed_out) else $error("loop not closed");
	a_confirm_one_cycle: assert property (s_confirm |=> !l3_confirm_out) else $error("confirm too long");
	a_closed_by_confirm: assert property ($rose(loop_closed_out) |-> $past(l3_confirm_out))
		else $error("closed without confirm");
	a_audio_exclusive: assert property (loop_closed_out |-> !dai_allowed_out) else $error("audio port with loop");
	a_sim_removal_opens: assert property ($fell(test_sim_present_in) |-> ##[1:5] !loop_closed_out)
		else $error("loop kept after sim removal");
	a_power_down_opens: assert property ($rose(power_down_in) |-> ##[1:5] !loop_closed_out)
		else $error("loop kept after power down");
	a_frame_length: assert property (enc_valid_out |-> enc_len_out ==
		((chan_at_close == tlc_pkg::TLC_CH_EFR) ? tlc_pkg::EFR_BITS : tlc_pkg::SPEECH_BITS))
		else $error("wrong frame length");
	a_efr_top_zero: assert property (enc_valid_out && enc_len_out == tlc_pkg::EFR_BITS |->
		enc_bits_out[259:244] == 16'h0000) else $error("bits above enhanced length");
	a_burst_on_tick: assert property (ul_burst_valid_out |-> $past(frame_tick_in) && $past(burst_loop_live_out))
		else $error("burst outside frame tick");
endmodule
bind tlc_loop_ctrl tlc_loop_ctrl_properties u_props (.clk_sys_in, .rstn_in, .frame_tick_in, .l3_close_req_in,
	.tch_active_in, .tch_type_in, .test_sim_present_in, .power_down_in, .dai_active_in, .enc_valid_out,
	.enc_bits_out, .enc_len_out, .ul_burst_valid_out, .l3_confirm_out, .loop_closed_out, .burst_loop_live_out,
	.dai_allowed_out);

// >>> verif/tlc_sim_model.sv
// Far side stand-in: frame timing and encoder acceptance
`timescale 1ns/10ps
module tlc_sim_model #(
	parameter int TICK_CYC = 16
) (
	input  wire logic clk_in,
	input  wire logic rstn_in,
	input  wire logic stall_in,
	output logic      frame_tick_out,
	output logic      enc_ready_out
);
	logic [7:0] cnt_reg;
	// Slow encoder shown as plain back-pressure
	assign enc_ready_out = !stall_in;
	assign frame_tick_out = (cnt_reg == 8'h00);
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) cnt_reg <= 8'h00;
		else cnt_reg <= (cnt_reg == 8'(TICK_CYC - 1)) ? 8'h00 : cnt_reg + 8'h01;
	end
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the test loop controller
`timescale 1ns/10ps
module testbench;
	logic                clk = 1'b0, rstn = 1'b0, creq = 1'b0, oreq = 1'b0, tch = 1'b0, sim = 1'b1;
	logic                pdn = 1'b0, digital_audio_test_port = 1'b0, dv = 1'b0, bv = 1'b0, stall = 1'b0;
	logic                tick, rdy, enc_v, ulv, conf, closed, live, dai_ok, full;
	logic [259:0]        enc_bits;
	logic [113:0]        ul_bits;
	logic [8:0]          enc_len;
	tlc_pkg::tlc_loop_t  loop = tlc_pkg::TLC_LOOP_A;
	tlc_pkg::tlc_chan_t  chan = tlc_pkg::TLC_CH_FULL;
	tlc_pkg::tlc_frame_t frame = '0;
	tlc_pkg::tlc_burst_t burst = '0;
	int                  fail_count = 0, n_checks = 0, cyc = 0, w;
	tlc_sim_model #(.TICK_CYC(16)) sim_side (.clk_in(clk), .rstn_in(rstn), .stall_in(stall),
		.frame_tick_out(tick), .enc_ready_out(rdy));
	tlc_loop_ctrl dut (.clk_sys_in(clk), .rstn_in(rstn), .frame_tick_in(tick), .l3_close_req_in(creq),
		.l3_close_loop_in(loop), .l3_open_req_in(oreq), .tch_active_in(tch), .tch_type_in(chan),
		.test_sim_present_in(sim), .power_down_in(pdn), .dai_active_in(digital_audio_test_port), .dec_valid_in(dv),
		.dec_frame_in(frame), .burst_valid_in(bv), .burst_in(burst), .enc_ready_in(rdy), .enc_valid_out(enc_v),
		.enc_bits_out(enc_bits), .enc_len_out(enc_len), .ul_burst_valid_out(ulv), .ul_burst_out(ul_bits),
		.l3_confirm_out(conf), .loop_closed_out(closed), .burst_loop_live_out(live), .dai_allowed_out(dai_ok),
		.fifo_full_out(full));
	initial forever #5 clk = ~clk;
	task automatic chk(input logic [259:0] got, input logic [259:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic close_loop(input tlc_pkg::tlc_loop_t l, input logic e_conf, input logic e_closed);
		@(posedge clk);
		creq <= 1'b1;
		loop <= l;
		@(posedge clk);
		creq <= 1'b0;
		#1 chk(conf, e_conf);
		@(posedge clk) #1 chk(closed, e_closed);
	endtask
	task automatic open_loop();
		@(posedge clk);
		oreq <= 1'b1;
		@(posedge clk);
		oreq <= 1'b0;
		repeat (2) @(posedge clk) #1;
		chk(closed, 1'b0);
	endtask
	task automatic send_frame(input logic [259:0] b, input logic bad, input logic [259:0] exp);
		@(posedge clk);
		dv <= 1'b1;
		frame <= '{b, bad, 1'b0, 1'b0, tlc_pkg::SID_VALID};
		@(posedge clk);
		dv <= 1'b0;
		#1 chk(enc_v, 1'b1);
		chk(enc_bits, exp);
	endtask
	task automatic t_refusal();
		close_loop(tlc_pkg::TLC_LOOP_A, 1'b0, 1'b0);
		chk(dai_ok, 1'b1);
		tch <= 1'b1;
		digital_audio_test_port <= 1'b1;
		close_loop(tlc_pkg::TLC_LOOP_A, 1'b0, 1'b0);
		digital_audio_test_port <= 1'b0;
	endtask
	task automatic t_loop_a();
		close_loop(tlc_pkg::TLC_LOOP_A, 1'b1, 1'b1);
		chk(dai_ok, 1'b0);
		close_loop(tlc_pkg::TLC_LOOP_B, 1'b0, 1'b1);
		send_frame({65{4'hA}}, 1'b0, {65{4'hA}});
		chk(enc_len, tlc_pkg::SPEECH_BITS);
		send_frame({65{4'hA}}, 1'b1, 260'h0);
		open_loop();
		chan <= tlc_pkg::TLC_CH_EFR;
		close_loop(tlc_pkg::TLC_LOOP_A, 1'b1, 1'b1);
		// Length is fixed when the loop closes
		chan <= tlc_pkg::TLC_CH_FULL;
		send_frame('1, 1'b0, {16'h0000, {244{1'b1}}});
		chk(enc_len, tlc_pkg::EFR_BITS);
		pdn <= 1'b1;
		repeat (6) @(posedge clk);
		pdn <= 1'b0;
		#1 chk(closed, 1'b0);
		repeat (4) @(posedge clk);
	endtask
	// Bad flag set on purpose: this loop must not zero it; no fast control sent
	task automatic t_loop_b();
		close_loop(tlc_pkg::TLC_LOOP_B, 1'b1, 1'b1);
		send_frame({65{4'h5}}, 1'b1, {65{4'h5}});
		sim <= 1'b0;
		repeat (6) @(posedge clk);
		sim <= 1'b1;
		#1 chk(closed, 1'b0);
		repeat (6) @(posedge clk);
	endtask
	// Slow and idle bursts first, then exactly eight that fill the buffer
	task automatic t_loop_c();
		close_loop(tlc_pkg::TLC_LOOP_C, 1'b1, 1'b1);
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			bv <= 1'b1;
			burst <= '{114'(i), i == 0, i == 1};
		end
		@(posedge clk);
		bv <= 1'b0;
		@(posedge clk) #1 chk(full, 1'b1);
		for (w = 0; w < 600 && ulv !== 1'b1; w++) @(posedge clk) #1;
		chk(ul_bits, 260'h2);
		chk(live, 1'b1);
		chk(w < 26 * 16, 1'b1);
		@(posedge clk) #1;
		for (w = 0; w < 40 && ulv !== 1'b1; w++) @(posedge clk) #1;
		chk(ul_bits, 260'h3);
		open_loop();
	endtask
	// Flags are bad, unreliable, fast control, then the two silence class bits
	task automatic send_flagged(input logic [4:0] fl, input logic [259:0] exp);
		@(posedge clk);
		dv <= 1'b1;
		frame <= {{65{4'h9}}, fl};
		@(posedge clk);
		dv <= 1'b0;
		#1 chk(enc_bits, exp);
		chk(enc_v, !stall);
	endtask
	// Stall on the last frame: bits still follow, but no encoder strobe
	task automatic t_loops_def();
		close_loop(tlc_pkg::TLC_LOOP_D, 1'b1, 1'b1);
		send_flagged(5'h0A, 260'h0);
		send_flagged(5'h12, 260'h0);
		send_flagged(5'h02, {65{4'h9}});
		open_loop();
		close_loop(tlc_pkg::TLC_LOOP_E, 1'b1, 1'b1);
		send_flagged(5'h01, {65{4'h9}});
		send_flagged(5'h00, 260'h0);
		open_loop();
		close_loop(tlc_pkg::TLC_LOOP_F, 1'b1, 1'b1);
		send_flagged(5'h01, 260'h0);
		stall <= 1'b1;
		send_flagged(5'h02, {65{4'h9}});
		stall <= 1'b0;
		open_loop();
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			fail_count++;
			complete_run();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
		t_refusal();
		t_loop_a();
		t_loop_b();
		t_loop_c();
		t_loops_def();
		complete_run();
	end
endmodule
